/* dct_bist_model.sv */
// Self-test engine model driving the self-test inputs.
// Assumes it alone drives them, just after MCLK rises.
`timescale 1ns/1ps
`default_nettype none
module dct_bist_model
  import dct_pkg::*;
(
  input  wire logic        clk,
  output logic [IDX_W-1:0] addr,
  output logic [IDX_W-1:0] sts_addr,
  output logic [TAG_W-1:0] tag,
  output logic [STS_W-1:0] sts,
  output logic             we0,
  output logic             we1,
  output logic [STS_W-1:0] sts_we,
  output logic             en,
  output logic             wb_sel
);
  // Idle, powered up, way 0 on the writeback output
  initial begin
    {addr, sts_addr, tag, sts, we0, we1, sts_we, wb_sel} = '0;
    en = 1'b1;
  end
  task automatic put(input logic [IDX_W-1:0] i, input logic [TAG_W-1:0] t,
                     input logic [STS_W-1:0] s, input logic a, input logic b);
    @(posedge clk);
    addr <= i;
    sts_addr <= i;
    tag <= t;
    sts <= s;
    we0 <= a;
    we1 <= b;
    sts_we <= {STS_W{a}};
    @(posedge clk);
    {we0, we1, sts_we} <= '0;
    sts <= ~s;
  endtask
endmodule
`default_nettype wire

/* dct_en_latch.sv */
// Enable latch for the status array, open while the clock is low.
// Assumes the enable settles before the rising edge.
`timescale 1ns/1ps
`default_nettype none
module dct_en_latch (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic en,
  output logic      q
);
  // Transparent on the low phase, closed while high
  always_latch begin
    if (!rst_n) begin
      q = 1'b0;
    end else if (!clk) begin
      q = en;
    end
  end
endmodule
`default_nettype wire

/* dct_pkg.sv */
// Constants, state layout and shared helpers of the data cache tag memory.
// Assumes one clock; all users import the whole package.
package dct_pkg;

  // Line index taken from address bits 12 down to 4
  localparam int IDX_HI = 12;
  localparam int IDX_LO = 4;
  localparam int IDX_W  = IDX_HI - IDX_LO + 1;
  // Stored widths
  localparam int TAG_W  = 19;
  localparam int STS_W  = 5;
  // Equality comparator width: tag plus a constant qualifier bit
  localparam int CMP_W  = 20;

  // Register bus map, byte addresses of aligned words
  localparam int          APB_AW     = 12;
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;

  // Control register fields
  localparam int   CTRL_PDN_BIT = 0;
  localparam logic CTRL_PDN_RST = 1'b0;

  // Status register fields
  localparam int ST_WAY0_BIT = 0;
  localparam int ST_WAY1_BIT = 1;
  localparam int ST_TEST_BIT = 2;
  localparam int ST_PDN_BIT  = 3;

  // Values after reset
  localparam logic [TAG_W-1:0] TAG_RST  = 19'h00000;
  localparam logic [STS_W-1:0] STS_RST  = 5'h00;
  localparam logic [31:0]      WORD_RST = 32'h00000000;

  // Every register of the top module in one word
  typedef struct packed {
    logic             way0_match;
    logic             way1_match;
    logic [TAG_W-1:0] wb_tag;
    logic [STS_W-1:0] status_out;
    logic [TAG_W-1:0] test_tag_a;
    logic [TAG_W-1:0] test_tag_b;
    logic             pdn_ctrl;
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
  } dct_state_t;

  // 20-bit equality compare of a stored tag against a key
  function automatic logic dct_tag_equal(input logic [TAG_W-1:0] stored,
                                         input logic [TAG_W-1:0] key);
    logic [CMP_W-1:0] a;
    logic [CMP_W-1:0] b;
    a = {1'b1, stored};
    b = {1'b1, key};
    return a == b;
  endfunction

endpackage

/* dct_ram.sv */
// Storage array with bit-strobed synchronous write and asynchronous read.
// Assumes strobes are already gated for power-down by the user side.
`timescale 1ns/1ps
`default_nettype none
module dct_ram #(
  parameter int W  = 19,
  parameter int AW = 9
) (
  input wire logic clk,
  dct_ram_if.store port
);
  import dct_pkg::*;

  // Refuse shapes the array cannot serve
  if (W < 1 || AW < 1 || $bits(port.wr_data) != W ||
      $bits(port.wr_idx) != AW) begin : g_bad_shape
    $error("dct_ram: width or depth does not match its port");
  end

  logic [W-1:0] mem [2**AW];  // One word per line

  // Each strobe bit writes only its own data bit
  always_ff @(posedge clk) begin
    for (int i = 0; i < W; i++) begin
      if (port.wr_bits[i]) begin
        mem[port.wr_idx][i] <= port.wr_data[i];
      end
    end
  end

  // Read returns the contents before any write at this edge
  assign port.rd_data = mem[port.rd_idx];
endmodule
`default_nettype wire

/* dct_ram_if.sv */
// Port bundle between the tag memory control and one storage array.
// Assumes the storage side reads asynchronously and writes on the clock.
`timescale 1ns/1ps
`default_nettype none
interface dct_ram_if #(
  parameter int W  = 19,
  parameter int AW = 9
);
  logic [AW-1:0] rd_idx;   // Read line
  logic [W-1:0]  rd_data;  // Read word
  logic [AW-1:0] wr_idx;   // Write line
  logic [W-1:0]  wr_bits;  // Per-bit write strobes
  logic [W-1:0]  wr_data;  // Write word

  // Control side
  modport user  (output rd_idx, wr_idx, wr_bits, wr_data, input rd_data);
  // Storage side
  modport store (input rd_idx, wr_idx, wr_bits, wr_data, output rd_data);
endinterface
`default_nettype wire

/* dct_top.sv */
// Two-way data cache tag and status memory with hit compare and test mux.
// Assumes controller and self-test engine run on MCLK; APB on MCLK too.
//
// Operation
// - Test select swaps in all self-test inputs.
// - Way-1 match high when way-1 tag equals key.
// - Way-0 match high when way-0 tag equals key.
// - Writeback tag output shows selected way's tag.
// - One index, address 12:4, reads tags and status.
// - Status writes use their own index.
// - Enable low powers down, high operates while CTRL bit 0 is clear.
// - Five status bits per line, strobed, read out.
// - Tag input is write data; compare key is compare operand.
// - Writeback select picks tag for writeback address.
// - Every functional input but the compare key has a self-test twin; way select and tag strobe become two per-way strobes.
// - Match through 20-bit equality comparator, both ways.
// - Testable by self-test ports, no repair.
// - Way select high writes way 1, low way 0.
// - Tag strobe at edge writes selected way.
// - Each status strobe writes its own bit.
`timescale 1ns/1ps
`default_nettype none
module dct_top
  import dct_pkg::*;
(
  input  wire logic              MCLK,
  input  wire logic              RST_N,
  // Functional side
  input  wire logic [IDX_HI:IDX_LO] ADDR,
  input  wire logic [IDX_HI:IDX_LO] STATUS_WRITE_ADDR,
  input  wire logic [TAG_W-1:0]  TAG_IN,
  input  wire logic [TAG_W-1:0]  COMPARE_KEY,
  input  wire logic [STS_W-1:0]  STATUS_IN,
  input  wire logic              WAY_WRITE_SELECT,
  input  wire logic              WRITEBACK_WAY_SELECT,
  input  wire logic              TAG_STROBE,
  input  wire logic [STS_W-1:0]  STATUS_STROBE,
  input  wire logic              ENABLE,
  // Self-test side
  input  wire logic              TEST_SELECT,
  input  wire logic [IDX_W-1:0]  SELFTEST_ADDR,
  input  wire logic [IDX_W-1:0]  SELFTEST_STATUS_ADDR,
  input  wire logic [TAG_W-1:0]  SELFTEST_TAG_IN,
  input  wire logic [STS_W-1:0]  SELFTEST_STATUS_IN,
  input  wire logic              SELFTEST_WAY0_TAG_STROBE,
  input  wire logic              SELFTEST_WAY1_TAG_STROBE,
  input  wire logic [STS_W-1:0]  SELFTEST_STATUS_STROBE,
  input  wire logic              SELFTEST_ENABLE,
  input  wire logic              SELFTEST_WRITEBACK_WAY_SELECT,
  // Results
  output logic [TAG_W-1:0]       WRITEBACK_TAG,
  output logic [STS_W-1:0]       STATUS_OUT,
  output logic                   WAY1_MATCH,
  output logic                   WAY0_MATCH,
  output logic [TAG_W-1:0]       SELFTEST_TAG_OUT_A,
  output logic [TAG_W-1:0]       SELFTEST_TAG_OUT_B,
  // APB register slave
  input  wire logic [APB_AW-1:0] PADDR,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [31:0]       PWDATA,
  output logic [31:0]            PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR
);

  dct_state_t state;       // All registers of this module
  dct_state_t next_state;  // Their next values

  // Selected inputs after the test mux
  logic [IDX_W-1:0] sel_idx;     // Read and tag write line
  logic [IDX_W-1:0] sel_sidx;    // Status write line
  logic [TAG_W-1:0] sel_tag;     // Tag write data
  logic [TAG_W-1:0] sel_key;     // Compare operand
  logic [STS_W-1:0] sel_sts;     // Status write data
  logic [STS_W-1:0] sel_sstrb;   // Status strobes
  logic             sel_we0;     // Way 0 tag strobe
  logic             sel_we1;     // Way 1 tag strobe
  logic             sel_en;      // Enable before software gating
  logic             sel_wbsel;   // Writeback way choice
  logic             run;         // Arrays active this cycle
  logic             sts_run;     // Enable as seen by the status array
  logic             apb_setup;   // Access phase waiting for answer
  logic             apb_done;    // Transfer completes at this edge
  logic             apb_hit;     // Address decodes to a register
  logic [31:0]      rd_word;     // Read data to be returned

  // Storage ports
  dct_ram_if #(.W(TAG_W), .AW(IDX_W)) tag0_if ();
  dct_ram_if #(.W(TAG_W), .AW(IDX_W)) tag1_if ();
  dct_ram_if #(.W(STS_W), .AW(IDX_W)) sts_if ();

  // Way 0 tags
  dct_ram #(.W(TAG_W), .AW(IDX_W)) u_tag0 (
    .clk  (MCLK),
    .port (tag0_if.store)
  );

  // Way 1 tags
  dct_ram #(.W(TAG_W), .AW(IDX_W)) u_tag1 (
    .clk  (MCLK),
    .port (tag1_if.store)
  );

  // Status bits
  dct_ram #(.W(STS_W), .AW(IDX_W)) u_sts (
    .clk  (MCLK),
    .port (sts_if.store)
  );

  // Status enable through a latch open while the clock is low
  dct_en_latch u_sts_en (
    .clk   (MCLK),
    .rst_n (RST_N),
    .en    (run),
    .q     (sts_run)
  );

  // Input mux between functional and self-test sources
  always_comb begin
    if (TEST_SELECT) begin
      sel_idx   = SELFTEST_ADDR;
      sel_sidx  = SELFTEST_STATUS_ADDR;
      sel_tag   = SELFTEST_TAG_IN;
      // Self-test has no key of its own; its tag data is compared
      sel_key   = SELFTEST_TAG_IN;
      sel_sts   = SELFTEST_STATUS_IN;
      sel_sstrb = SELFTEST_STATUS_STROBE;
      sel_we0   = SELFTEST_WAY0_TAG_STROBE;
      sel_we1   = SELFTEST_WAY1_TAG_STROBE;
      sel_en    = SELFTEST_ENABLE;
      sel_wbsel = SELFTEST_WRITEBACK_WAY_SELECT;
    end else begin
      sel_idx   = ADDR;
      sel_sidx  = STATUS_WRITE_ADDR;
      sel_tag   = TAG_IN;
      sel_key   = COMPARE_KEY;
      sel_sts   = STATUS_IN;
      sel_sstrb = STATUS_STROBE;
      sel_we0   = TAG_STROBE & ~WAY_WRITE_SELECT;
      sel_we1   = TAG_STROBE & WAY_WRITE_SELECT;
      sel_en    = ENABLE;
      sel_wbsel = WRITEBACK_WAY_SELECT;
    end
  end

  assign run = sel_en & ~state.pdn_ctrl;

  // Array ports: both ways and status read at one index
  always_comb begin
    tag0_if.rd_idx  = sel_idx;
    tag1_if.rd_idx  = sel_idx;
    sts_if.rd_idx   = sel_idx;
    tag0_if.wr_idx  = sel_idx;
    tag1_if.wr_idx  = sel_idx;
    sts_if.wr_idx   = sel_sidx;
    tag0_if.wr_data = sel_tag;
    tag1_if.wr_data = sel_tag;
    sts_if.wr_data  = sel_sts;
    tag0_if.wr_bits = {TAG_W{sel_we0 & run}};
    tag1_if.wr_bits = {TAG_W{sel_we1 & run}};
    sts_if.wr_bits  = sel_sstrb & {STS_W{sts_run}};
  end

  // APB decode and read data
  assign apb_setup = PSEL & PENABLE & ~state.pready;
  assign apb_done  = PSEL & PENABLE & state.pready;
  assign apb_hit   = (PADDR == REG_CTRL) || (PADDR == REG_STATUS);

  // Read word for the addressed register
  always_comb begin
    rd_word = WORD_RST;
    if (PADDR == REG_CTRL) begin
      rd_word[CTRL_PDN_BIT] = state.pdn_ctrl;
    end else if (PADDR == REG_STATUS) begin
      rd_word[ST_WAY0_BIT] = state.way0_match;
      rd_word[ST_WAY1_BIT] = state.way1_match;
      rd_word[ST_TEST_BIT] = TEST_SELECT;
      rd_word[ST_PDN_BIT]  = ~run;
    end
  end

  // Next state of results and bus slave
  always_comb begin
    next_state = state;
    if (run) begin
      next_state.way0_match = dct_tag_equal(tag0_if.rd_data, sel_key);
      next_state.way1_match = dct_tag_equal(tag1_if.rd_data, sel_key);
      next_state.wb_tag     = sel_wbsel ? tag1_if.rd_data
                                        : tag0_if.rd_data;
      next_state.status_out = sts_if.rd_data;
      next_state.test_tag_a = tag0_if.rd_data;
      next_state.test_tag_b = tag1_if.rd_data;
    end
    // One wait state, then answer for one cycle
    next_state.pready = apb_setup;
    if (apb_setup) begin
      next_state.prdata  = (PWRITE || !apb_hit) ? WORD_RST : rd_word;
      next_state.pslverr = ~apb_hit;
    end else begin
      next_state.prdata  = WORD_RST;
      next_state.pslverr = 1'b0;
    end
    // Write takes effect at the completing edge
    if (apb_done && PWRITE && PADDR == REG_CTRL) begin
      next_state.pdn_ctrl = PWDATA[CTRL_PDN_BIT];
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= '{way0_match: 1'b0, way1_match: 1'b0, wb_tag: TAG_RST,
                 status_out: STS_RST, test_tag_a: TAG_RST,
                 test_tag_b: TAG_RST, pdn_ctrl: CTRL_PDN_RST,
                 pready: 1'b0, pslverr: 1'b0, prdata: WORD_RST};
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register
  assign WAY0_MATCH         = state.way0_match;
  assign WAY1_MATCH         = state.way1_match;
  assign WRITEBACK_TAG      = state.wb_tag;
  assign STATUS_OUT         = state.status_out;
  assign SELFTEST_TAG_OUT_A = state.test_tag_a;
  assign SELFTEST_TAG_OUT_B = state.test_tag_b;
  assign PREADY             = state.pready;
  assign PSLVERR            = state.pslverr;
  assign PRDATA             = state.prdata;

endmodule
`default_nettype wire

/* dct_top_properties.sv */
// Port checker of the tag memory, bound into its top module.
// Assumes one clock; mirrors the software power-down bit.
`timescale 1ns/1ps
`default_nettype none
module dct_top_properties
  import dct_pkg::*;
(
  input wire logic                 MCLK,
  input wire logic                 RST_N,
  input wire logic [IDX_HI:IDX_LO] ADDR,
  input wire logic [IDX_HI:IDX_LO] STATUS_WRITE_ADDR,
  input wire logic [TAG_W-1:0]     TAG_IN,
  input wire logic [TAG_W-1:0]     COMPARE_KEY,
  input wire logic [STS_W-1:0]     STATUS_IN,
  input wire logic                 WAY_WRITE_SELECT,
  input wire logic                 WRITEBACK_WAY_SELECT,
  input wire logic                 TAG_STROBE,
  input wire logic [STS_W-1:0]     STATUS_STROBE,
  input wire logic                 ENABLE,
  input wire logic                 TEST_SELECT,
  input wire logic [TAG_W-1:0]     WRITEBACK_TAG,
  input wire logic [STS_W-1:0]     STATUS_OUT,
  input wire logic                 WAY1_MATCH,
  input wire logic                 WAY0_MATCH,
  input wire logic [TAG_W-1:0]     SELFTEST_TAG_OUT_A,
  input wire logic [TAG_W-1:0]     SELFTEST_TAG_OUT_B,
  input wire logic [APB_AW-1:0]    PADDR,
  input wire logic                 PSEL,
  input wire logic                 PENABLE,
  input wire logic                 PWRITE,
  input wire logic [31:0]          PWDATA,
  input wire logic                 PREADY
);
  logic pdn; // Software power-down
  logic run; // Functional access taken
  assign run = ENABLE && !pdn && !TEST_SELECT;
  // Follow CTRL bit0 at the edge its write completes
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N)
      pdn <= 1'b0;
    else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == REG_CTRL)
      pdn <= PWDATA[CTRL_PDN_BIT];
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  a_way0_match_key:
    assert property (run |=> WAY0_MATCH ==
      (SELFTEST_TAG_OUT_A == $past(COMPARE_KEY))) else $error("way0 match");
  a_way1_match_key:
    assert property (run |=> WAY1_MATCH ==
      (SELFTEST_TAG_OUT_B == $past(COMPARE_KEY))) else $error("way1 match");
  a_wb_tag_select:
    assert property (run |=> WRITEBACK_TAG == ($past(WRITEBACK_WAY_SELECT)
      ? SELFTEST_TAG_OUT_B : SELFTEST_TAG_OUT_A)) else $error("wb tag");
  a_tag_write_way1:
    assert property (run && TAG_STROBE && WAY_WRITE_SELECT ##1 run &&
      ADDR == $past(ADDR) |=> SELFTEST_TAG_OUT_B == $past(TAG_IN, 2))
    else $error("way1 write");
  a_tag_write_way0:
    assert property (run && TAG_STROBE && !WAY_WRITE_SELECT ##1 run &&
      ADDR == $past(ADDR) |=> SELFTEST_TAG_OUT_A == $past(TAG_IN, 2))
    else $error("way0 write");
  a_status_bit_write:
    assert property (run && STATUS_STROBE != 5'h00 ##1 run &&
      ADDR == $past(STATUS_WRITE_ADDR) |=> ((STATUS_OUT ^ $past(STATUS_IN, 2))
      & $past(STATUS_STROBE, 2)) == 5'h00) else $error("status write");
  a_hold_match:
    assert property (!run && !TEST_SELECT |=> $stable(WAY0_MATCH) &&
      $stable(WAY1_MATCH)) else $error("match moved");
  a_hold_data:
    assert property (!run && !TEST_SELECT |=> $stable(WRITEBACK_TAG) &&
      $stable(STATUS_OUT)) else $error("data moved");
endmodule
bind dct_top dct_top_properties dct_top_properties_i (.*);
`default_nettype wire

/* tb_top.sv */
// Self-checking bench of the tag memory and its self-test model.
// Assumes a 20 MHz MCLK and the package constants.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dct_pkg::*;
;
  logic MCLK, RST_N, WAY_WRITE_SELECT, WRITEBACK_WAY_SELECT, TAG_STROBE;
  logic ENABLE, TEST_SELECT, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic WAY0_MATCH, WAY1_MATCH, SELFTEST_WAY0_TAG_STROBE, SELFTEST_ENABLE;
  logic SELFTEST_WAY1_TAG_STROBE, SELFTEST_WRITEBACK_WAY_SELECT, ls, e;
  logic [IDX_HI:IDX_LO] ADDR, STATUS_WRITE_ADDR;
  logic [IDX_W-1:0]     SELFTEST_ADDR, SELFTEST_STATUS_ADDR;
  logic [TAG_W-1:0]     TAG_IN, COMPARE_KEY, SELFTEST_TAG_IN, lk;
  logic [TAG_W-1:0]     WRITEBACK_TAG, SELFTEST_TAG_OUT_A, SELFTEST_TAG_OUT_B;
  logic [STS_W-1:0]     STATUS_IN, STATUS_STROBE, STATUS_OUT;
  logic [STS_W-1:0]     SELFTEST_STATUS_IN, SELFTEST_STATUS_STROBE;
  logic [APB_AW-1:0]    PADDR;
  logic [31:0]          PWDATA, PRDATA, q;
  logic [TAG_W-1:0]     w0 [512];   // Expected way 0 tags
  logic [TAG_W-1:0]     w1 [512];   // Expected way 1 tags
  logic [STS_W-1:0]     sm [512];   // Expected status words
  logic                 live;       // Writes expected to land
  int                   li, miscompares, total_checks;

  dct_top dct_top_i (.*);
  dct_bist_model dct_bist_model_i (
    .clk(MCLK), .addr(SELFTEST_ADDR), .sts_addr(SELFTEST_STATUS_ADDR),
    .tag(SELFTEST_TAG_IN), .sts(SELFTEST_STATUS_IN),
    .we0(SELFTEST_WAY0_TAG_STROBE), .we1(SELFTEST_WAY1_TAG_STROBE),
    .sts_we(SELFTEST_STATUS_STROBE), .en(SELFTEST_ENABLE),
    .wb_sel(SELFTEST_WRITEBACK_WAY_SELECT));

  // Clock, 50 ns period
  always #25 MCLK = ~MCLK;

  task automatic cmp(input string n, input logic [31:0] x,
                     input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer, bounded wait for the answer
  task automatic apb(input logic w, input logic [APB_AW-1:0] a,
                     input logic [31:0] d);
    int n;
    // Setup cycle: request and qualifiers launched after a rising edge
    @(posedge MCLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, d};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    // Access phase: answer is taken only at a rising edge with ready high
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    cmp("pready", 1, PREADY);
    if (PREADY !== 1'b1)
      end_of_test();
    q = PRDATA;
    e = PSLVERR;
    // Release right after the completing edge
    {PSEL, PENABLE} <= 2'b00;
  endtask
  // Outputs against the expected line li, key lk, select ls
  task automatic check;
    cmp("way0 match", w0[li] == lk, WAY0_MATCH);
    cmp("way1 match", w1[li] == lk, WAY1_MATCH);
    cmp("wb tag", ls ? w1[li] : w0[li], WRITEBACK_TAG);
    cmp("status", sm[li], STATUS_OUT);
    cmp("tag a", w0[li], SELFTEST_TAG_OUT_A);
    cmp("tag b", w1[li], SELFTEST_TAG_OUT_B);
  endtask
  task automatic wtag(input int i, input logic w, input logic [TAG_W-1:0] t);
    @(posedge MCLK);
    {ADDR, WAY_WRITE_SELECT, TAG_IN, TAG_STROBE} <= {i[8:0], w, t, 1'b1};
    if (live && w)
      w1[i] = t;
    else if (live)
      w0[i] = t;
  endtask
  task automatic wsts(input int i, input logic [4:0] s, input logic [4:0] m);
    @(posedge MCLK);
    {STATUS_WRITE_ADDR, STATUS_IN, STATUS_STROBE} <= {i[8:0], s, m};
    if (live)
      sm[i] = (sm[i] & ~m) | (s & m);
  endtask
  // Read a line; when hold is set the previous result must stay
  task automatic look(input int i, input logic [TAG_W-1:0] k, input logic s,
                      input logic hold);
    @(posedge MCLK);
    {TAG_STROBE, STATUS_STROBE} <= '0;
    {ADDR, COMPARE_KEY, WRITEBACK_WAY_SELECT} <= {i[8:0], k, s};
    if (!hold)
      {li, lk, ls} = {i, k, s};
    @(posedge MCLK);
    @(negedge MCLK);
    check();
  endtask

  // Main sequence
  initial begin
    {MCLK, RST_N, ADDR, STATUS_WRITE_ADDR, TAG_IN, COMPARE_KEY} = '0;
    {STATUS_IN, WAY_WRITE_SELECT, WRITEBACK_WAY_SELECT, TAG_STROBE} = '0;
    {STATUS_STROBE, PADDR, PSEL, PENABLE, PWRITE, PWDATA} = '0;
    {ENABLE, TEST_SELECT, live, miscompares, total_checks} = {3'b111, 64'h0};
    repeat (10) @(posedge MCLK);
    RST_N <= 1'b1;
    for (int i = 0; i < 512; i++) begin
      dct_bist_model_i.put(i[8:0], {i[8:0], 10'h2A5}, i[4:0], 1'b1, 1'b1);
      w0[i] = {i[8:0], 10'h2A5};
      w1[i] = w0[i];
      sm[i] = i[4:0];
    end
    $display("fill done");
    @(posedge MCLK);
    {ADDR, TAG_STROBE, STATUS_STROBE} <= {9'd9, 1'b1, 5'h1F};
    dct_bist_model_i.put(9'd5, 19'h12345, 5'h0A, 1'b1, 1'b0);
    {w0[5], sm[5], li, lk, ls} = {19'h12345, 5'h0A, 32'd5, 19'h12345, 1'b0};
    @(posedge MCLK);
    @(negedge MCLK);
    check();
    @(posedge MCLK);
    {TAG_STROBE, STATUS_STROBE, TEST_SELECT} <= '0;
    $display("test mode done");
    wtag(40, 1'b0, 19'h3C3C0);
    wtag(40, 1'b1, 19'h3C3C1);
    look(40, 19'h3C3C0, 1'b0, 1'b0);
    look(40, 19'h3C3C1, 1'b1, 1'b0);
    look(40, 19'h00001, 1'b0, 1'b0);
    for (int b = 0; b < 5; b++) begin
      wsts(60, ~sm[60], 5'h01 << b);
      look(60, 19'h0, 1'b0, 1'b0);
    end
    $display("tag and status done");
    @(posedge MCLK);
    ENABLE <= 1'b0;
    live = 1'b0;
    wtag(70, 1'b0, 19'h7FFFF);
    wsts(70, 5'h1F, 5'h1F);
    look(71, 19'h7FFFF, 1'b1, 1'b1);
    @(posedge MCLK);
    ENABLE <= 1'b1;
    live = 1'b1;
    look(70, w0[70], 1'b0, 1'b0);
    $display("enable done");
    apb(1'b0, REG_CTRL, 0);
    cmp("ctrl reset", 0, q);
    apb(1'b1, REG_CTRL, 1);
    apb(1'b0, REG_STATUS, 0);
    cmp("powered down", 1, q[ST_PDN_BIT]);
    live = 1'b0;
    wtag(70, 1'b1, 19'h11111);
    look(70, 19'h11111, 1'b1, 1'b1);
    apb(1'b1, REG_CTRL, 0);
    live = 1'b1;
    look(70, w1[70], 1'b1, 1'b0);
    apb(1'b0, 12'h0FC, 0);
    cmp("unmapped err", 1, e);
    cmp("unmapped data", 0, q);
    $display("registers done");
    end_of_test();
  end
endmodule
`default_nettype wire
